// file: hdl/pccap_pkg.sv
// Package of register map, field layout and build settings for the capability bank
package pccap_pkg;
   // AXI4-Lite byte addresses of the capability words
   localparam logic [7:0] PCCAP_OFS_PCIE_CAP = 8'h00;
   localparam logic [7:0] PCCAP_OFS_DEV_CAP = 8'h04;
   localparam logic [7:0] PCCAP_OFS_LINK_CAP = 8'h08;
   localparam logic [7:0] PCCAP_OFS_DEV_CAP2 = 8'h0C;
   localparam logic [7:0] PCCAP_OFS_MSI_CTRL = 8'h10;
   localparam logic [7:0] PCCAP_OFS_RTY_INFO = 8'h14;
   // Field values and positions
   localparam logic [3:0] PCCAP_CAP_VERSION = 4'h2;
   // Kept above the 25-bit field so that field reads back as configured
   localparam int PCCAP_RO_BIT = 28;
   localparam int PCCAP_MLW_LSB = 4;
   localparam int PCCAP_MMC_LSB = 1;
   localparam int PCCAP_MME_LSB = 4;
   // Build settings
   localparam logic [2:0] PCCAP_MPS = 3'h1;
   localparam logic [24:0] PCCAP_DEVCAP_27_3 = 25'h0000000;
   localparam logic PCCAP_RELAXED_ORD = 1'b1;
   localparam logic [5:0] PCCAP_MAX_LINK_W = 6'h04;
   localparam logic [4:0] PCCAP_DEVCAP2_4_0 = 5'h00;
   localparam logic PCCAP_USE_MSI = 1'b1;
   localparam logic [2:0] PCCAP_MSI_REQ = 3'h2;
   // Response codes
   localparam logic [1:0] PCCAP_RESP_OKAY = 2'h0;
   localparam logic [1:0] PCCAP_RESP_SLVERR = 2'h2;
   localparam logic [31:0] PCCAP_ZERO = 32'h00000000;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } pccap_rd_s;
endpackage

// file: hdl/pccap_rtybuf.sv
// Retry buffer sizing from the payload setting
`timescale 1ns/1ps
module pccap_rtybuf
   import pccap_pkg::*;
(
   // Setting
   input wire logic [2:0] mps,
   // Result in bytes
   output logic [15:0] rty_bytes
);
   function automatic logic [15:0] size_of(input logic [2:0] m);
      // Small payloads still get the 512B block memory floor
      if (m <= 3'h1) begin
         size_of = 16'h0200;
      end else begin
         size_of = 16'(16'h0080 << m) << 1;
      end
   endfunction
   assign rty_bytes = size_of(mps);
endmodule

// file: hdl/pccap_bank.sv
// AXI4-Lite capability register bank with MSI grant output
`timescale 1ns/1ps
module pccap_bank
   import pccap_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // User side
   output logic [2:0] msi_granted_count,
   output logic msi_enabled
);
   logic [7:0] awaddr_q, awaddr_d;
   logic aw_have_q, aw_have_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic w_have_q, w_have_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [7:0] rd_addr_q, rd_addr_d;
   logic aw_rdy_q, w_rdy_q, ar_rdy_q;
   pccap_rd_s rd_q, rd_d;
   logic [2:0] mme_q, mme_d;
   logic msi_en_q, msi_en_d;
   logic [15:0] rty_bytes;

   pccap_rtybuf u_rty (
      .mps(PCCAP_MPS),
      .rty_bytes(rty_bytes)
   );

   // Fixed capability words
   wire [31:0] pcie_cap_w = {28'h0000000, PCCAP_CAP_VERSION};
   wire [31:0] dev_cap_w = {4'h0, PCCAP_DEVCAP_27_3, PCCAP_MPS};
   wire [31:0] link_cap_w = {22'h000000, PCCAP_MAX_LINK_W, 4'h0};
   wire [31:0] dev_cap2_w = {27'h0000000, PCCAP_DEVCAP2_4_0};
   // Relaxed ordering changes only this reported bit; no ordering logic exists
   wire [31:0] dev_ctl_ro = PCCAP_ZERO | (32'(PCCAP_RELAXED_ORD) << PCCAP_RO_BIT);
   wire [31:0] msi_w = PCCAP_USE_MSI ?
      {24'h000000, 1'b0, mme_q, PCCAP_MSI_REQ, msi_en_q} : PCCAP_ZERO;

   // Address decode
   wire do_wr = aw_have_q && w_have_q && !bvalid_q;
   wire wr_msi = do_wr && awaddr_q == PCCAP_OFS_MSI_CTRL;
   wire wr_known = awaddr_q == PCCAP_OFS_PCIE_CAP || awaddr_q == PCCAP_OFS_DEV_CAP ||
      awaddr_q == PCCAP_OFS_LINK_CAP || awaddr_q == PCCAP_OFS_DEV_CAP2 ||
      awaddr_q == PCCAP_OFS_MSI_CTRL || awaddr_q == PCCAP_OFS_RTY_INFO;
   wire rd_take = s_axi_arvalid && !rvalid_q;
   logic [31:0] rsel;
   logic rhit;
   always_comb begin
      rhit = 1'b1;
      if (s_axi_araddr == PCCAP_OFS_PCIE_CAP) begin
         rsel = pcie_cap_w;
      end else if (s_axi_araddr == PCCAP_OFS_DEV_CAP) begin
         rsel = dev_cap_w | dev_ctl_ro;
      end else if (s_axi_araddr == PCCAP_OFS_LINK_CAP) begin
         rsel = link_cap_w;
      end else if (s_axi_araddr == PCCAP_OFS_DEV_CAP2) begin
         rsel = dev_cap2_w;
      end else if (s_axi_araddr == PCCAP_OFS_MSI_CTRL) begin
         rsel = msi_w;
      end else if (s_axi_araddr == PCCAP_OFS_RTY_INFO) begin
         rsel = {16'h0000, rty_bytes};
      end else begin
         rsel = PCCAP_ZERO;
         rhit = 1'b0;
      end
   end

   // Next state
   always_comb begin
      awaddr_d = awaddr_q;
      aw_have_d = aw_have_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      w_have_d = w_have_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rd_d = rd_q;
      rd_addr_d = rd_addr_q;
      mme_d = mme_q;
      msi_en_d = msi_en_q;
      if (s_axi_awvalid && !aw_have_q) begin
         awaddr_d = s_axi_awaddr;
         aw_have_d = 1'b1;
      end
      if (s_axi_wvalid && !w_have_q) begin
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
         w_have_d = 1'b1;
      end
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_known ? PCCAP_RESP_OKAY : PCCAP_RESP_SLVERR;
      end
      // Only system-granted enable and count are writable; the rest is fixed
      if (wr_msi && PCCAP_USE_MSI && wstrb_q[0]) begin
         msi_en_d = wdata_q[0];
         // Grant above the request is clipped to keep the count legal
         mme_d = (wdata_q[6:4] > PCCAP_MSI_REQ) ? PCCAP_MSI_REQ : wdata_q[6:4];
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (rd_take) begin
         rvalid_d = 1'b1;
         rd_d.data = rsel;
         rd_addr_d = s_axi_araddr;
         rd_d.resp = rhit ? PCCAP_RESP_OKAY : PCCAP_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         awaddr_q <= 8'h00;
         aw_have_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         rvalid_q <= 1'b0;
         rd_q <= '0;
         rd_addr_q <= 8'h00;
         aw_rdy_q <= 1'b1;
         w_rdy_q <= 1'b1;
         ar_rdy_q <= 1'b1;
         mme_q <= 3'h0;
         msi_en_q <= 1'b0;
      end else begin
         awaddr_q <= awaddr_d;
         aw_have_q <= aw_have_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         w_have_q <= w_have_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rd_q <= rd_d;
         rd_addr_q <= rd_addr_d;
         aw_rdy_q <= !aw_have_d;
         w_rdy_q <= !w_have_d;
         ar_rdy_q <= !rvalid_d;
         mme_q <= mme_d;
         msi_en_q <= msi_en_d;
      end
   end

   // Outputs, ready flags are registered holding-slot vacancies
   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready = w_rdy_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ar_rdy_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rd_q.data;
   assign s_axi_rresp = rd_q.resp;
   assign msi_granted_count = mme_q;
   assign msi_enabled = msi_en_q;

   // Read-data checks watch the registered answer in rd_q, so a broken read decode is caught too
   sequence s_msi_store;
      wr_msi && wstrb_q[0] && PCCAP_USE_MSI;
   endsequence
   a_version_fixed: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_PCIE_CAP
      |-> rd_q.data[3:0] == 4'h2) else $error("version not two");
   a_rty_floor: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_RTY_INFO && PCCAP_MPS <= 3'h1
      |-> rd_q.data == 32'h00000200) else $error("retry size wrong");
   a_mps_adv: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_DEV_CAP
      |-> rd_q.data[2:0] == PCCAP_MPS) else $error("payload field wrong");
   a_devcap_field: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_DEV_CAP
      |-> rd_q.data[27:3] == PCCAP_DEVCAP_27_3) else $error("devcap field wrong");
   a_ro_bit: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_DEV_CAP
      |-> rd_q.data[PCCAP_RO_BIT] == PCCAP_RELAXED_ORD && rd_q.data[31:29] == 3'h0)
      else $error("relaxed bit wrong");
   a_link_width: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_LINK_CAP
      |-> rd_q.data[9:4] == PCCAP_MAX_LINK_W) else $error("link width wrong");
   a_devcap2_field: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_DEV_CAP2
      |-> rd_q.data[4:0] == PCCAP_DEVCAP2_4_0) else $error("devcap2 wrong");
   a_msi_absent: assert property (@(posedge mclk) disable iff (rst)
      rvalid_q && rd_addr_q == PCCAP_OFS_MSI_CTRL
      |-> rd_q.data[3:1] == (PCCAP_USE_MSI ? PCCAP_MSI_REQ : 3'h0)) else $error("msi word bad");
   a_grant_hold: assert property (@(posedge mclk) disable iff (rst)
      !wr_msi |=> $stable(mme_q) && $stable(msi_en_q)) else $error("grant moved");
   a_grant_limit: assert property (@(posedge mclk) disable iff (rst)
      msi_granted_count <= (PCCAP_USE_MSI ? PCCAP_MSI_REQ : 3'h0)) else $error("grant over request");
   a_grant_store: assert property (@(posedge mclk) disable iff (rst)
      s_msi_store |=> msi_enabled == $past(wdata_q[0])) else $error("enable not stored");
   a_read_answer: assert property (@(posedge mclk) disable iff (rst)
      rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
endmodule

// file: verif/pccap_host.sv
// Model of system software issuing AXI4-Lite configuration accesses
`timescale 1ns/1ps
module pccap_host (
   // Clock
   input wire logic mclk,
   // Write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   logic stuck = 1'b0;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // One access at a time, so transmit order stays strict
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      int n;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64 && !bvalid; n++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      r = bresp;
      if (!bvalid) stuck = 1'b1;
      // Released lines show garbage, not the last value
      awaddr <= ~a;
      wdata <= ~d;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64 && !rvalid; n++) begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      if (!rvalid) stuck = 1'b1;
      araddr <= ~a;
      rready <= 1'b0;
   endtask
endmodule

// file: verif/pcie_cap_msi_config_params_tb.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
module pcie_cap_msi_config_params_tb;
   import pccap_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr, araddr, wa;
   logic [31:0] wdata, rdata, mv, seed = 32'h2B8B5C13;
   logic [3:0] wstrb, st;
   logic en = 1'b0;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, msi_enabled;
   logic [2:0] msi_granted_count, gr = 3'h0;
   int bad_count = 0;
   int total_checks = 0;
   always #2.5 mclk = ~mclk;
   pccap_bank i_dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .msi_granted_count(msi_granted_count), .msi_enabled(msi_enabled));
   pccap_host i_host (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] fixed_word(input logic [7:0] a);
      case (a)
         PCCAP_OFS_PCIE_CAP: return {28'h0, PCCAP_CAP_VERSION};
         PCCAP_OFS_DEV_CAP: return {4'h0, PCCAP_DEVCAP_27_3, PCCAP_MPS}
            | ({31'h0, PCCAP_RELAXED_ORD} << PCCAP_RO_BIT);
         PCCAP_OFS_LINK_CAP: return {26'h0, PCCAP_MAX_LINK_W} << PCCAP_MLW_LSB;
         PCCAP_OFS_DEV_CAP2: return {27'h0, PCCAP_DEVCAP2_4_0};
         PCCAP_OFS_RTY_INFO: return (PCCAP_MPS < 3'h2) ? 32'h200 : 32'h100 << PCCAP_MPS;
         default: return 32'h0;
      endcase
   endfunction
   // Grant comes in already clipped to the request; word reads zero without MSI
   function automatic logic [31:0] msi_word(input logic [2:0] g, input logic e);
      return PCCAP_USE_MSI ? ({29'h0, g} << PCCAP_MME_LSB) | ({29'h0, PCCAP_MSI_REQ}
         << PCCAP_MMC_LSB) | {31'h0, e} : 32'h0;
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
      if (i_host.stuck) begin
         bad_count++;
         end_of_test();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      i_host.rd(a, d, r);
      check(d, ed);
      check({30'h0, r}, {30'h0, er});
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic [1:0] r;
      i_host.wr(a, d, s, r);
      check({30'h0, r}, {30'h0, er});
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      check({28'h0, msi_enabled, msi_granted_count}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wa = 8'(i * 4);
         mv = (wa == PCCAP_OFS_MSI_CTRL) ? msi_word(3'h0, 1'b0) : fixed_word(wa);
         rd_chk(wa, mv, PCCAP_RESP_OKAY);
      end
      rd_chk(8'h18, PCCAP_ZERO, PCCAP_RESP_SLVERR);
      wr_chk(8'hFC, 32'hFFFFFFFF, 4'hF, PCCAP_RESP_SLVERR);
      $display("test reset values done");
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         wa = {3'h0, seed[7:5] % 3'h5, 2'h0};
         if (wa == PCCAP_OFS_MSI_CTRL) wa = PCCAP_OFS_RTY_INFO;
         wr_chk(wa, seed ^ 32'hA5A5A5A5, 4'hF, PCCAP_RESP_OKAY);
         for (int a = 0; a < 24; a += 4) begin
            if (a != 16) rd_chk(8'(a), fixed_word(8'(a)), PCCAP_RESP_OKAY);
         end
         mv = (i == 0) ? 32'h00000071 : (i == 1) ? 32'h0 : seed;
         st = (i < 2) ? 4'hF : seed[11:8];
         wr_chk(PCCAP_OFS_MSI_CTRL, mv, st, PCCAP_RESP_OKAY);
         // Low strobe lane clear: stored grant and enable must stay put
         if (st[0]) begin
            gr = (mv[6:4] > PCCAP_MSI_REQ) ? PCCAP_MSI_REQ : mv[6:4];
            en = mv[0];
         end
         rd_chk(PCCAP_OFS_MSI_CTRL, msi_word(gr, en), PCCAP_RESP_OKAY);
         if (PCCAP_USE_MSI) begin
            check({28'h0, msi_enabled, msi_granted_count}, {28'h0, en, gr});
         end
      end
      $display("test read-only and grant done");
      end_of_test();
   end
endmodule
